/* core/cpualu_defs.svh */
`ifndef CPUALU_DEFS_SVH
`define CPUALU_DEFS_SVH
// Overview of operation
// - Half-carry from bit 3 byte, bit 7 word
// - Status bits 7-5 hold priority level
// - Control bit 3 extends level; blocks interrupts
// - Level field read-only while nesting disabled
// - Level MSB resets zero, software only clears
// - Loop flag follows hardware loop, read-only
// - Negative flag tracks result sign
// - Overflow flag marks signed overflow
// - Zero flag cleared by non-zero result
// - Carry flag marks carry out of MSB
// - Subtraction carries act as not-borrow indicators
// - Control bit 2 enables program window
// - Unimplemented bits read zero; all reset zero
// - ALU works in byte or word width
// - Operands from registers or memory, either destination
// - Multiplier is a 17x17 signed array
// - Signed, unsigned, mixed, literal, byte multiply modes
// - Divide 32/16 and 16/16, signed and unsigned
// - Quotient to register 0, remainder register 1
// - Dividend from even register pair, high odd
// - One divide step per divisor bit
// - Divide runs in 19-cycle loop, interruptible
// - Shift up to 16 positions in one cycle
// - Signed count: positive right, negative left

// Register offsets
`define CA_OFS_STATUS   8'h00
`define CA_OFS_CONTROL  8'h04
// Status word fields
`define CA_SR_DC        8
`define CA_SR_IPL       5
`define CA_SR_RA        4
`define CA_SR_N         3
`define CA_SR_OV        2
`define CA_SR_Z         1
`define CA_SR_C         0
// Control word fields
`define CA_CC_IPLMSB    3
`define CA_CC_PWE       2
// Reset values
`define CA_RST_STATUS   16'h0000
`define CA_RST_CONTROL  16'h0000
// Divide timing and destinations
`define CA_DIV_STEPS    5'h10
`define CA_DIV_LOOP     5'h13
`define CA_QUO_WREG     4'h0
`define CA_REM_WREG     4'h1
// Largest shift magnitude
`define CA_SH_MAX       6'h10
`endif

/* core/cpualu_pkg.sv */
package cpualu_pkg;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR,
    ALU_MOV, ALU_SHA, ALU_SHL, ALU_MUL
  } cpualu_op_t;

  typedef enum logic [2:0] {
    MUL_SS, MUL_UU, MUL_US, MUL_SU, MUL_SLIT, MUL_ULIT, MUL_B8
  } cpualu_mul_t;

  typedef struct packed {
    cpualu_op_t  op;
    cpualu_mul_t mul_mode;
    logic        byte_mode;
    logic        a_mem;
    logic        b_mem;
    logic        dst_mem;
    logic [3:0]  dst_wreg;
  } cpualu_req_t;

  typedef struct packed {
    logic [31:0] data;
    logic        wide;
    logic        dst_mem;
    logic [3:0]  dst_wreg;
  } cpualu_res_t;

  typedef struct packed {
    logic        signed_div;
    logic        wide;
    logic [31:0] dividend;
    logic [15:0] divisor;
  } cpualu_div_req_t;

endpackage

/* core/cpualu_div.sv */
`timescale 1ns/100ps
`include "cpualu_defs.svh"

module cpualu_div
  import cpualu_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // Request
  input  wire logic             start,
  input  wire logic             step_en,
  input  wire cpualu_div_req_t  req,
  // Result
  output logic                  busy_q,
  output logic                  done_q,
  output logic [15:0]           quo_q,
  output logic [15:0]           rem_q
);

  typedef enum logic [1:0] {DV_IDLE, DV_CALC, DV_FIX} cpualu_dv_st_t;

  cpualu_dv_st_t st_q;
  logic [15:0]   dvs_q;
  logic [4:0]    cnt_q;
  logic          negq_q;
  logic          negr_q;
  logic [31:0]   dext;
  logic [31:0]   dmag;
  logic [15:0]   smag;
  logic [16:0]   part;
  logic          ge;

  always_comb
  begin
    dext = req.wide ? req.dividend
         : req.signed_div ? {{16{req.dividend[15]}}, req.dividend[15:0]}
         : {16'h0000, req.dividend[15:0]};
    dmag = (req.signed_div && dext[31]) ? 32'(-dext) : dext;
    smag = (req.signed_div && req.divisor[15]) ? 16'(-req.divisor) : req.divisor;
    part = {rem_q, quo_q[15]};
    ge   = part >= {1'b0, dvs_q};
  end

  // Quotient assumed to fit 16 bits: high half below divisor
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q   <= DV_IDLE;
      dvs_q  <= 16'h0000;
      cnt_q  <= 5'h00;
      negq_q <= 1'b0;
      negr_q <= 1'b0;
      quo_q  <= 16'h0000;
      rem_q  <= 16'h0000;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      unique case (st_q)
        DV_IDLE:
          if (start)
          begin
            st_q   <= DV_CALC;
            rem_q  <= dmag[31:16];
            quo_q  <= dmag[15:0];
            dvs_q  <= smag;
            cnt_q  <= 5'h00;
            negq_q <= req.signed_div & (dext[31] ^ req.divisor[15]);
            negr_q <= req.signed_div & dext[31];
          end
        DV_CALC:
          // Stalled steps keep all partial state for interrupts
          if (step_en)
          begin
            rem_q <= ge ? 16'(part - {1'b0, dvs_q}) : part[15:0];
            quo_q <= {quo_q[14:0], ge};
            cnt_q <= 5'(cnt_q + 5'h01);
            if (cnt_q == 5'(`CA_DIV_STEPS - 5'h01))
              st_q <= DV_FIX;
          end
        DV_FIX:
        begin
          quo_q  <= negq_q ? 16'(-quo_q) : quo_q;
          rem_q  <= negr_q ? 16'(-rem_q) : rem_q;
          done_q <= 1'b1;
          st_q   <= DV_IDLE;
        end
      endcase
    end
  end

  assign busy_q = (st_q != DV_IDLE);

endmodule

/* core/cpualu_core.sv */
`timescale 1ns/100ps
`include "cpualu_defs.svh"

module cpualu_core
  import cpualu_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // APB slave
  input  wire logic [7:0]       paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata_q,
  output logic                  pready_q,
  output logic                  pslverr_q,
  // Operation from decode
  input  wire logic             op_valid,
  input  wire cpualu_req_t      req,
  input  wire logic [15:0]      wreg_a,
  input  wire logic [15:0]      wreg_b,
  input  wire logic [15:0]      mem_a,
  input  wire logic [15:0]      mem_b,
  // Divide from sequencer
  input  wire logic             div_start,
  input  wire logic             div_step,
  input  wire cpualu_div_req_t  div_req,
  // Sequencer state
  input  wire logic             repeat_active,
  input  wire logic             nesting_disable,
  input  wire logic             ipl_load,
  input  wire logic [3:0]       ipl_value,
  // Results
  output logic                  res_valid_q,
  output cpualu_res_t           res_q,
  output logic                  div_busy_q,
  output logic                  div_done_q,
  // Status and control
  output logic [15:0]           status_word,
  output logic [3:0]            cpu_priority,
  output logic                  user_irq_block_q,
  output logic                  prog_window_en_q
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic        dc_q;
  logic [2:0]  ipl_q;
  logic        ra_q;
  logic        n_q;
  logic        ov_q;
  logic        z_q;
  logic        c_q;
  logic        ipl_msb_q;
  logic [2:0]  ipl_d;
  logic        ipl_msb_d;
  logic [15:0] div_quo;
  logic [15:0] div_rem;

  // ----------------------------------------------------------------
  // APB slave, zero wait state
  // ----------------------------------------------------------------
  logic        setup;
  logic        wr_acc;
  logic        wr_status;
  logic        wr_control;
  logic [15:0] status_rd;
  logic [15:0] control_rd;

  assign setup      = psel & ~penable;
  assign wr_acc     = psel & penable & pwrite & pready_q;
  assign wr_status  = wr_acc & (paddr == `CA_OFS_STATUS);
  assign wr_control = wr_acc & (paddr == `CA_OFS_CONTROL);

  assign status_rd  = {7'h00, dc_q, ipl_q, ra_q, n_q, ov_q, z_q, c_q};
  assign control_rd = {12'h000, ipl_msb_q, prog_window_en_q, 2'h0};

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= setup;
      pslverr_q <= setup & (paddr != `CA_OFS_STATUS) & (paddr != `CA_OFS_CONTROL);
      if (setup)
      begin
        unique case (paddr)
          `CA_OFS_STATUS:  prdata_q <= {16'h0000, status_rd};
          `CA_OFS_CONTROL: prdata_q <= {16'h0000, control_rd};
          default:         prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Operand select and adder
  // ----------------------------------------------------------------
  logic [15:0] opa;
  logic [15:0] opb;
  logic [15:0] addb;
  logic        is_sub;
  logic [4:0]  s5;
  logic [8:0]  s9;
  logic [16:0] s17;

  always_comb
  begin
    opa    = req.a_mem ? mem_a : wreg_a;
    opb    = req.b_mem ? mem_b : wreg_b;
    is_sub = (req.op == ALU_SUB);
    // Subtract as a + ~b + 1, so carries read as not-borrow
    addb   = is_sub ? ~opb : opb;
    s5     = {1'b0, opa[3:0]} + {1'b0, addb[3:0]} + {4'h0, is_sub};
    s9     = {1'b0, opa[7:0]} + {1'b0, addb[7:0]} + {8'h00, is_sub};
    s17    = {1'b0, opa} + {1'b0, addb} + {16'h0000, is_sub};
  end

  // ----------------------------------------------------------------
  // Shifter
  // ----------------------------------------------------------------
  logic [5:0]  sh_cnt;
  logic        sh_left;
  logic [5:0]  sh_raw;
  logic [5:0]  sh_mag;
  logic [15:0] sh_src;
  logic [15:0] sh_out;

  always_comb
  begin
    sh_cnt  = opb[5:0];
    sh_left = sh_cnt[5];
    sh_raw  = sh_left ? 6'(-sh_cnt) : sh_cnt;
    // Six bits so that the 32-place magnitude of a -32 count stays representable before the clamp
    sh_mag  = (sh_raw > `CA_SH_MAX) ? `CA_SH_MAX : sh_raw;
    if (!req.byte_mode)
      sh_src = opa;
    else if (req.op == ALU_SHA)
      sh_src = {{8{opa[7]}}, opa[7:0]};
    else
      sh_src = {8'h00, opa[7:0]};
    if (sh_left)
      sh_out = sh_src << sh_mag;
    else if (req.op == ALU_SHA)
      sh_out = 16'($signed(sh_src) >>> sh_mag);
    else
      sh_out = sh_src >> sh_mag;
  end

  // ----------------------------------------------------------------
  // Multiplier
  // ----------------------------------------------------------------
  logic [16:0] ma;
  logic [16:0] mb;
  logic [33:0] prod;

  always_comb
  begin
    unique case (req.mul_mode)
      MUL_SS:   begin ma = {opa[15], opa}; mb = {opb[15], opb}; end
      MUL_UU:   begin ma = {1'b0, opa};    mb = {1'b0, opb};    end
      MUL_US:   begin ma = {1'b0, opa};    mb = {opb[15], opb}; end
      MUL_SU:   begin ma = {opa[15], opa}; mb = {1'b0, opb};    end
      MUL_SLIT: begin ma = {opa[15], opa}; mb = {12'h000, opb[4:0]}; end
      MUL_ULIT: begin ma = {1'b0, opa};    mb = {12'h000, opb[4:0]}; end
      MUL_B8:   begin ma = {9'h000, opa[7:0]}; mb = {9'h000, opb[7:0]}; end
      default:  begin ma = 17'h00000;      mb = 17'h00000;      end
    endcase
    // Extra sign bit lets one signed array serve all modes
    prod = 34'($signed(ma) * $signed(mb));
  end

  // ----------------------------------------------------------------
  // Result and flags
  // ----------------------------------------------------------------
  logic [15:0] alu_r;
  logic [15:0] res16;
  logic        f_n;
  logic        f_z;
  logic        f_c;
  logic        f_dc;
  logic        f_ov;
  logic        upd_all;
  logic        upd_nz;

  always_comb
  begin
    unique case (req.op)
      ALU_ADD, ALU_SUB: alu_r = s17[15:0];
      ALU_AND:          alu_r = opa & opb;
      ALU_IOR:          alu_r = opa | opb;
      ALU_XOR:          alu_r = opa ^ opb;
      ALU_MOV:          alu_r = opb;
      ALU_SHA, ALU_SHL: alu_r = sh_out;
      ALU_MUL:          alu_r = prod[15:0];
      default:          alu_r = 16'h0000;
    endcase
    // Byte ops pass the upper byte of operand A through to the result
    res16 = req.byte_mode ? {opa[15:8], alu_r[7:0]} : alu_r;
    f_n   = req.byte_mode ? res16[7] : res16[15];
    f_z   = req.byte_mode ? (res16[7:0] == 8'h00) : (res16 == 16'h0000);
    f_dc  = req.byte_mode ? s5[4] : s9[8];
    f_c   = req.byte_mode ? s9[8] : s17[16];
    f_ov  = req.byte_mode
          ? (opa[7] == addb[7]) && (s9[7] != opa[7])
          : (opa[15] == addb[15]) && (s17[15] != opa[15]);
    upd_all = op_valid && (req.op == ALU_ADD || req.op == ALU_SUB);
    upd_nz  = op_valid && (req.op != ALU_MUL);
  end

  // Arithmetic flags: operation beats a same-cycle software write
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      n_q  <= 1'b0;
      z_q  <= 1'b0;
      c_q  <= 1'b0;
      dc_q <= 1'b0;
      ov_q <= 1'b0;
    end
    else
    begin
      if (upd_nz)
      begin
        n_q <= f_n;
        z_q <= f_z;
      end
      else if (wr_status)
      begin
        n_q <= pwdata[`CA_SR_N];
        z_q <= pwdata[`CA_SR_Z];
      end
      if (upd_all)
      begin
        c_q  <= f_c;
        dc_q <= f_dc;
        ov_q <= f_ov;
      end
      else if (wr_status)
      begin
        c_q  <= pwdata[`CA_SR_C];
        dc_q <= pwdata[`CA_SR_DC];
        ov_q <= pwdata[`CA_SR_OV];
      end
    end
  end

  // ----------------------------------------------------------------
  // Priority level and control word
  // ----------------------------------------------------------------
  always_comb
  begin
    ipl_d     = ipl_q;
    ipl_msb_d = ipl_msb_q;
    if (ipl_load)
    begin
      ipl_d     = ipl_value[2:0];
      ipl_msb_d = ipl_value[3];
    end
    else
    begin
      if (wr_status && !nesting_disable)
        ipl_d = pwdata[`CA_SR_IPL +: 3];
      if (wr_control && !pwdata[`CA_CC_IPLMSB])
        ipl_msb_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ipl_q            <= 3'h0;
      ipl_msb_q        <= 1'b0;
      user_irq_block_q <= 1'b0;
    end
    else
    begin
      ipl_q            <= ipl_d;
      ipl_msb_q        <= ipl_msb_d;
      user_irq_block_q <= ipl_msb_d | (&ipl_d);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      prog_window_en_q <= 1'b0;
    else if (wr_control)
      prog_window_en_q <= pwdata[`CA_CC_PWE];
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      ra_q <= 1'b0;
    else
      ra_q <= repeat_active;
  end

  assign status_word  = status_rd;
  assign cpu_priority = {ipl_msb_q, ipl_q};

  // ----------------------------------------------------------------
  // Divider and result register
  // ----------------------------------------------------------------
  cpualu_div u_div
  (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .start   (div_start),
    .step_en (div_step),
    .req     (div_req),
    .busy_q  (div_busy_q),
    .done_q  (div_done_q),
    .quo_q   (div_quo),
    .rem_q   (div_rem)
  );

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      res_valid_q <= 1'b0;
      res_q       <= '0;
    end
    else
    begin
      res_valid_q <= div_done_q | op_valid;
      if (div_done_q)
      begin
        // Pair write: remainder lands in the register above
        res_q.data     <= {div_rem, div_quo};
        res_q.wide     <= 1'b1;
        res_q.dst_mem  <= 1'b0;
        res_q.dst_wreg <= `CA_QUO_WREG;
      end
      else if (op_valid)
      begin
        res_q.data     <= (req.op == ALU_MUL) ? prod[31:0] : {16'h0000, res16};
        res_q.wide     <= (req.op == ALU_MUL);
        res_q.dst_mem  <= req.dst_mem;
        res_q.dst_wreg <= req.dst_wreg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_div_go;
    div_start && !div_busy_q;
  endsequence

  sequence s_div_steps;
    div_step[*8] ##1 div_step[*8];
  endsequence

  a_half_carry_word: assert property (
    (upd_all && req.op == ALU_ADD && !req.byte_mode) |=>
      dc_q == (({1'b0, $past(opa[7:0])} + {1'b0, $past(opb[7:0])}) > 9'h0ff))
    else $error("half carry wrong for word add");

  a_ipl_locked: assert property (
    (wr_status && nesting_disable && !ipl_load) |=> $stable(ipl_q))
    else $error("priority field changed while locked");

  a_msb_clear_only: assert property (
    !ipl_load |=> !(ipl_msb_q && !$past(ipl_msb_q)))
    else $error("priority msb set by software");

  a_block_user_irq: assert property (
    user_irq_block_q == (ipl_msb_q || ipl_q == 3'h7))
    else $error("user interrupt block mismatch");

  a_loop_flag_track: assert property (
    ra_q == $past(repeat_active))
    else $error("loop flag does not follow loop");

  a_zero_flag_upd: assert property (
    (upd_nz && !req.byte_mode) |=> z_q == ($past(res16) == 16'h0000))
    else $error("zero flag wrong");

  a_flag_beats_sw: assert property (
    (upd_all && wr_status) |=> c_q == $past(f_c) && ov_q == $past(f_ov))
    else $error("software write beat flag update");

  a_div_timing: assert property (
    s_div_go ##1 s_div_steps |-> ##[1:2] div_done_q)
    else $error("divide not done after sixteen steps");

  a_div_dest: assert property (
    div_done_q |=> res_valid_q && res_q.dst_wreg == `CA_QUO_WREG
                   && res_q.data[15:0] == $past(div_quo))
    else $error("quotient not written to register 0");

  a_shift_zero: assert property (
    (op_valid && req.op == ALU_SHL && !req.byte_mode && opb[5:0] == 6'h00)
      |=> res_q.data[15:0] == $past(opa))
    else $error("zero shift changed operand");

endmodule

/* verification/cpualu_seq_model.sv */
`timescale 1ns/100ps

module cpualu_seq_model
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // Bench control
  input  wire logic go,
  input  wire logic stall,
  // Core side
  input  wire logic div_done_q,
  output logic      div_start,
  output logic      div_step,
  output logic      repeat_active
);
  logic [4:0] cnt_q;

  // --------
  // Divide loop
  // --------
  // Stall stands in for an interrupt taken inside the loop
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      div_start     <= 1'b0;
      div_step      <= 1'b0;
      repeat_active <= 1'b0;
      cnt_q         <= 5'h00;
    end
    else
    begin
      div_start <= go;
      if (go)
        repeat_active <= 1'b1;
      else if (div_done_q)
        repeat_active <= 1'b0;
      if (div_start)
        cnt_q <= 5'h00;
      else if (div_step)
        cnt_q <= cnt_q + 5'h01;
      // Never more than 16 steps, so the loop length stays fixed
      div_step <= ~stall & (div_start |
                  (repeat_active & ((cnt_q + {4'h0, div_step}) < 5'h10)));
    end
endmodule

/* verification/cpualu_core_tb.sv */
`timescale 1ns/100ps

module cpualu_core_tb
  import cpualu_pkg::*;
  ;
  logic clk_sys, nrst, psel, penable, pwrite, op_valid, nesting_disable, ipl_load, go, stall;
  logic pready_q, pslverr_q, div_start, div_step, repeat_active, res_valid_q, er;
  logic div_busy_q, div_done_q, user_irq_block_q, prog_window_en_q;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata_q, rd;
  logic [15:0]     wreg_a, wreg_b, mem_a, mem_b, status_word;
  logic [3:0]      ipl_value, cpu_priority;
  cpualu_req_t     req;
  cpualu_res_t     res_q;
  cpualu_div_req_t div_req;
  int              n_errors, checks, cyc;

  cpualu_core cpualu_core_i (.clk_sys, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata_q, .pready_q, .pslverr_q, .op_valid, .req, .wreg_a, .wreg_b, .mem_a, .mem_b,
    .div_start, .div_step, .div_req, .repeat_active, .nesting_disable, .ipl_load, .ipl_value,
    .res_valid_q, .res_q, .div_busy_q, .div_done_q, .status_word, .cpu_priority,
    .user_irq_block_q, .prog_window_en_q);
  cpualu_seq_model cpualu_seq_model_i (.clk_sys, .nrst, .go, .stall, .div_done_q, .div_start,
    .div_step, .repeat_active);

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // --------
  // Shared tasks
  // --------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready_q !== 1'b1);
    rd = prdata_q;
    er = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  // Flags masked to the arithmetic bits; level and loop bits left out
  task automatic alu(input cpualu_op_t op, input cpualu_mul_t m, input logic b8, am,
                     input logic [15:0] a, b, input logic [31:0] ed, input logic [15:0] ef);
    @(posedge clk_sys);
    op_valid <= 1'b1;
    req <= '{op, m, b8, am, 1'b0, 1'b0, 4'h2};
    wreg_a <= am ? ~a : a;
    mem_a <= am ? a : ~a;
    wreg_b <= b;
    mem_b <= ~b;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    #1;
    chk({31'h0, res_valid_q}, 32'h1);
    chk(res_q.data, ed);
    chk({16'h0, status_word & 16'h010f}, {16'h0, ef});
  endtask

  // --------
  // Scenarios
  // --------
  task automatic t_reset();
    apb(1'b0, 8'h00, 16'h0000);
    chk(rd, 32'h0);
    apb(1'b0, 8'h04, 16'h0000);
    chk(rd, 32'h0);
  endtask

  task automatic t_alu();
    alu(ALU_ADD, MUL_SS, 0, 0, 16'h7fff, 16'h0001, 32'h8000, 16'h010c);
    alu(ALU_SUB, MUL_SS, 0, 1, 16'h0005, 16'h0005, 32'h0, 16'h0103);
    alu(ALU_SUB, MUL_SS, 0, 0, 16'h0000, 16'h0001, 32'hffff, 16'h0008);
    alu(ALU_ADD, MUL_SS, 1, 0, 16'h12ff, 16'h0001, 32'h1200, 16'h0103);
    alu(ALU_SHA, MUL_SS, 0, 0, 16'h8000, 16'h0004, 32'hf800, 16'h0109);
    alu(ALU_SHL, MUL_SS, 0, 0, 16'h0001, 16'h003c, 32'h0010, 16'h0101);
    alu(ALU_SHL, MUL_SS, 0, 0, 16'h1234, 16'h0000, 32'h1234, 16'h0101);
    alu(ALU_SHL, MUL_SS, 0, 0, 16'h0001, 16'h0030, 32'h0000, 16'h0103);
    alu(ALU_XOR, MUL_SS, 0, 0, 16'ha5a5, 16'h5a5a, 32'hffff, 16'h0109);
    alu(ALU_MUL, MUL_SS, 0, 0, 16'hffff, 16'h0002, 32'hfffffffe, 16'h0109);
    alu(ALU_MUL, MUL_UU, 0, 0, 16'hffff, 16'h0002, 32'h0001fffe, 16'h0109);
    alu(ALU_MUL, MUL_US, 0, 0, 16'hffff, 16'hfffe, 32'hfffe0002, 16'h0109);
    alu(ALU_MUL, MUL_SU, 0, 0, 16'hffff, 16'hfffe, 32'hffff0002, 16'h0109);
    alu(ALU_MUL, MUL_SLIT, 0, 0, 16'hffff, 16'h001f, 32'hffffffe1, 16'h0109);
    alu(ALU_MUL, MUL_ULIT, 0, 0, 16'hffff, 16'h001f, 32'h001effe1, 16'h0109);
    alu(ALU_MUL, MUL_B8, 0, 0, 16'h12ff, 16'h3402, 32'h000001fe, 16'h0109);
  endtask

  task automatic t_sw();
    nesting_disable <= 1'b1;
    apb(1'b1, 8'h00, 16'hffff);
    chk({16'h0, status_word}, 32'h010f);
    nesting_disable <= 1'b0;
    apb(1'b1, 8'h00, 16'hffff);
    apb(1'b0, 8'h00, 16'h0000);
    chk(rd, 32'h01ef);
    chk({28'h0, cpu_priority}, 32'h7);
    chk({31'h0, user_irq_block_q}, 32'h1);
    apb(1'b1, 8'h00, 16'h0040);
    apb(1'b0, 8'h00, 16'h0000);
    chk({31'h0, user_irq_block_q}, 32'h0);
  endtask

  task automatic t_ctl();
    apb(1'b1, 8'h04, 16'hffff);
    apb(1'b0, 8'h04, 16'h0000);
    chk(rd, 32'h4);
    chk({31'h0, prog_window_en_q}, 32'h1);
    @(posedge clk_sys);
    ipl_load <= 1'b1;
    ipl_value <= 4'hc;
    @(posedge clk_sys);
    ipl_load <= 1'b0;
    apb(1'b0, 8'h04, 16'h0000);
    chk(rd, 32'hc);
    chk({28'h0, cpu_priority}, 32'hc);
    chk({31'h0, user_irq_block_q}, 32'h1);
    apb(1'b1, 8'h04, 16'h0000);
    chk({27'h0, cpu_priority, prog_window_en_q}, 32'h8);
    apb(1'b0, 8'h08, 16'h0000);
    chk({er, rd[30:0]}, 32'h80000000);
  endtask

  task automatic t_div(input logic sg, wd, input logic [31:0] dd, input logic [15:0] dv,
                       input logic [31:0] ex);
    @(posedge clk_sys);
    div_req <= '{sg, wd, dd, dv};
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (4) @(posedge clk_sys);
    stall <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk({31'h0, status_word[4]}, 32'h1);
    stall <= 1'b0;
    do @(posedge clk_sys); while (res_valid_q !== 1'b1);
    chk(res_q.data, ex);
    chk({28'h0, res_q.dst_wreg}, 32'h0);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({31'h0, status_word[4]}, 32'h0);
  endtask

  // --------
  // Sequence and hang guard
  // --------
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  initial
  begin
    {nrst, psel, penable, pwrite, op_valid, nesting_disable, ipl_load, go, stall} = '0;
    {paddr, pwdata, wreg_a, wreg_b, mem_a, mem_b, ipl_value} = '0;
    req = '0;
    div_req = '0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_alu();
    t_sw();
    t_ctl();
    t_div(1'b0, 1'b1, 32'h00010000, 16'h0003, 32'h00015555);
    t_div(1'b1, 1'b1, 32'hfffe7960, 16'h0007, 32'hfffbc833);
    t_div(1'b0, 1'b0, 32'h0000fff9, 16'h0002, 32'h00017ffc);
    t_div(1'b1, 1'b0, 32'hfffffff9, 16'h0002, 32'hfffffffd);
    end_of_test();
  end
endmodule
